// ### src/usbef_regs.svh
// Purpose: register map, field positions, reset values and timing counts of the usb event-flag block
// Assumes: 8-bit registers in the low byte of aligned 32-bit words, byte address = index * 4
// Notes: definitions only
`ifndef USBEF_REGS_SVH
`define USBEF_REGS_SVH

// register indices
`define USBEF_IDX_ADDR 10'h0e7
`define USBEF_IDX_EVT 10'h0e8
`define USBEF_IDX_ENA 10'h0e9
`define USBEF_IDX_CTRL0 10'h0ea
`define USBEF_IDX_CTRL1 10'h0eb

// event flag fields
`define USBEF_EVT_SUSPEND 7
`define USBEF_EVT_RSVD 6
`define USBEF_EVT_BUSRST 5
`define USBEF_EVT_TXD0 4
`define USBEF_EVT_RXD0 3
`define USBEF_EVT_TXD1 2
`define USBEF_EVT_EOP 1
`define USBEF_EVT_RESUME 0

// enable, address and control fields
`define USBEF_ENA_RSTCHIP 6
`define USBEF_ADDR_FUNC_ON 7
`define USBEF_CTRL0_TOGGLE 7
`define USBEF_CTRL0_STALL 6
`define USBEF_CTRL0_TXEN 5
`define USBEF_CTRL0_RXEN 4
`define USBEF_CTRL0_CNT_HI 3
`define USBEF_CTRL0_CNT_LO 0
`define USBEF_CTRL1_TXEN 5

// reset values
`define USBEF_RST_REG 8'h00

// bus answers
`define USBEF_RESP_OKAY 2'h0
`define USBEF_RESP_SLVERR 2'h2

// timing
`define USBEF_CLK_NS 100
`define USBEF_BUS_RESET_NS 2500
`define USBEF_BUS_RESET_CYC ((`USBEF_BUS_RESET_NS + `USBEF_CLK_NS - 1) / `USBEF_CLK_NS)

`endif

// ### src/usbef_pkg.sv
// Purpose: shared types of the usb event-flag block
// Assumes: nothing
// Notes: constants live in usbef_regs.svh
package usbef_pkg;

  typedef enum logic [1:0] {USBEF_HS_ACK, USBEF_HS_NAK, USBEF_HS_STALL, USBEF_HS_DATA} usbef_hs_t;

  typedef enum logic [1:0] {USBEF_LD_IDLE, USBEF_LD_SE0, USBEF_LD_RESET} usbef_line_t;

endpackage

// ### src/usbef_line_if.sv
// Purpose: line events passed from the line detector to the flag logic
// Assumes: one clock, all signals one-cycle pulses
// Notes: none
`timescale 1ns/1ps
interface usbef_line_if;
  logic busResetDet;
  logic eopDet;
  logic activityDet;

  modport det (output busResetDet, output eopDet, output activityDet);
  modport core (input busResetDet, input eopDet, input activityDet);
endinterface

// ### src/usbef_line_detect.sv
// Purpose: watches D+ and D- for bus reset, end of packet and activity
// Assumes: low-speed signalling, J is D- high, line inputs synchronous to mclk
// Notes: every output is a one-cycle pulse
`timescale 1ns/1ps
`include "usbef_regs.svh"
module usbef_line_detect #(
  parameter int RESET_CYCLES = `USBEF_BUS_RESET_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // line
  input wire logic dPlus,
  input wire logic dMinus,
  // events
  usbef_line_if.det ev
);
  import usbef_pkg::*;

  localparam int CW = $clog2(RESET_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(RESET_CYCLES - 1);

  usbef_line_t state;
  logic [CW-1:0] se0Cnt;
  logic lastJ;
  logic se0;
  logic jState;

  assign se0 = !dPlus && !dMinus;
  assign jState = dMinus && !dPlus;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= USBEF_LD_IDLE;
      se0Cnt <= '0;
      ev.busResetDet <= 1'b0;
      ev.eopDet <= 1'b0;
    end
    else
    begin
      ev.busResetDet <= 1'b0;
      ev.eopDet <= 1'b0;
      unique case (state)
        USBEF_LD_IDLE:
        begin
          se0Cnt <= CW'(1);
          if (se0)
            state <= USBEF_LD_SE0;
        end
        USBEF_LD_SE0:
        begin
          if (se0)
          begin
            se0Cnt <= se0Cnt + CW'(1);
            if (se0Cnt == CNT_LAST)
            begin
              ev.busResetDet <= 1'b1;
              state <= USBEF_LD_RESET;
            end
          end
          else
          begin
            // short se0 followed by J closes a packet; a K here is a glitch
            ev.eopDet <= jState;
            state <= USBEF_LD_IDLE;
          end
        end
        USBEF_LD_RESET:
        begin
          if (!se0)
            state <= USBEF_LD_IDLE;
        end
        default:
          state <= USBEF_LD_IDLE;
      endcase
    end
  end

  // activity is any departure from the idle J state
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      lastJ <= 1'b1;
      ev.activityDet <= 1'b0;
    end
    else
    begin
      lastJ <= jState;
      ev.activityDet <= lastJ && !jState;
    end
  end
endmodule

// ### src/usbef_core.sv
// Purpose: usb event flags, endpoint handshake choice and control registers behind an AXI4-Lite slave
// Assumes: the serial engine reports tokens, host ACKs and good OUT packets as one-cycle pulses
// Notes: handshake answer follows a token by one cycle
//
// Notes on behaviour
// - suspend stops usb clock, enters suspend state
// - bus reset on line sets read-only flag
// - bus reset with enable resets whole chip
// - host ACK after ep0 send sets done
// - good ep0 OUT packet sets receive done
// - ep0 rx done answers OUT with NAK
// - host ACK on interrupt pair sets done
// - interrupt tx done answers IN with NAK
// - end of packet sets flag, software clears
// - activity during suspend sets sticky resume flag
// - ep0 control: toggle, stall, txen, rxen, count
// - enable bit 6 routes bus reset chip-wide
// - ep0 IN NAK without enable or done
// - function off ignores every token
`timescale 1ns/1ps
`include "usbef_regs.svh"
module usbef_core #(
  parameter int RESET_CYCLES = `USBEF_BUS_RESET_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // usb line
  input wire logic dPlus,
  input wire logic dMinus,
  // serial engine events
  input wire logic tokenValid,
  input wire logic tokenIsIn,
  input wire logic [1:0] tokenEp,
  input wire logic hostAckValid,
  input wire logic [1:0] hostAckEp,
  input wire logic rxPacketOk,
  // handshake answer
  output logic hsValid,
  output usbef_pkg::usbef_hs_t hsKind,
  output logic hsToggle,
  output logic [3:0] txByteCount,
  // power and reset
  output logic usbClkRun,
  output logic usbSuspended,
  output logic chipReset
);
  import usbef_pkg::*;

  usbef_line_if lineEv ();

  usbef_line_detect #(
    .RESET_CYCLES(RESET_CYCLES)
  ) u_line (
    .mclk(mclk),
    .rst_b(rst_b),
    .dPlus(dPlus),
    .dMinus(dMinus),
    .ev(lineEv)
  );

  function automatic logic [9:0] regIndex(input logic [11:0] a);
    regIndex = a[11:2];
  endfunction

  function automatic logic isMapped(input logic [9:0] idx);
    isMapped = (idx == `USBEF_IDX_ADDR) || (idx == `USBEF_IDX_EVT) || (idx == `USBEF_IDX_ENA)
      || (idx == `USBEF_IDX_CTRL0) || (idx == `USBEF_IDX_CTRL1);
  endfunction

  logic [7:0] addrReg;
  logic [7:0] enaReg;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic suspendFlag;
  logic busResetFlag;
  logic txd0Flag;
  logic rxd0Flag;
  logic txd1Flag;
  logic eopFlag;
  logic resumeFlag;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic doWrite;
  logic [9:0] wrIdx;
  logic wrByte;
  logic modRst;
  logic funcOn;
  logic ep0Tok;
  logic intrTok;
  logic [7:0] evtRead;

  assign wrIdx = regIndex(wrAddr);
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrByte = doWrite && wrStrb[0];
  // the internal chip reset also restarts the usb module itself
  assign modRst = !rst_b || chipReset;
  assign funcOn = addrReg[`USBEF_ADDR_FUNC_ON];
  assign ep0Tok = tokenValid && funcOn && (tokenEp == 2'h0);
  assign intrTok = tokenValid && funcOn && tokenIsIn && (tokenEp != 2'h0);
  assign evtRead = {suspendFlag, 1'b0, busResetFlag, txd0Flag, rxd0Flag, txd1Flag, eopFlag, resumeFlag};

  // write channel: address and data taken in either order
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USBEF_RESP_OKAY;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wrAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(wrIdx) ? `USBEF_RESP_OKAY : `USBEF_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `USBEF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(regIndex(s_axi_araddr)) ? `USBEF_RESP_OKAY : `USBEF_RESP_SLVERR;
      unique case (regIndex(s_axi_araddr))
        `USBEF_IDX_ADDR: s_axi_rdata <= {24'h000000, addrReg};
        `USBEF_IDX_EVT: s_axi_rdata <= {24'h000000, evtRead};
        `USBEF_IDX_ENA: s_axi_rdata <= {24'h000000, enaReg};
        `USBEF_IDX_CTRL0: s_axi_rdata <= {24'h000000, ctrl0};
        `USBEF_IDX_CTRL1: s_axi_rdata <= {24'h000000, ctrl1};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // address and enables survive the internal reset so software can see what happened
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      addrReg <= `USBEF_RST_REG;
      enaReg <= `USBEF_RST_REG;
      ctrl1 <= `USBEF_RST_REG;
    end
    else if (wrByte)
    begin
      if (wrIdx == `USBEF_IDX_ADDR)
        addrReg <= wrData[7:0];
      if (wrIdx == `USBEF_IDX_ENA)
        enaReg <= wrData[7:0];
      if (wrIdx == `USBEF_IDX_CTRL1)
        ctrl1 <= wrData[7:0];
    end
  end

  // ep0 control; hardware drops force-stall once a token has been stalled
  always_ff @(posedge mclk)
  begin
    if (modRst)
      ctrl0 <= `USBEF_RST_REG;
    else if (wrByte && wrIdx == `USBEF_IDX_CTRL0)
      ctrl0 <= wrData[7:0];
    else if (ep0Tok && ctrl0[`USBEF_CTRL0_STALL])
      ctrl0[`USBEF_CTRL0_STALL] <= 1'b0;
  end

  // suspend is written by software only
  always_ff @(posedge mclk)
  begin
    if (modRst)
      suspendFlag <= 1'b0;
    else if (wrByte && wrIdx == `USBEF_IDX_EVT)
      suspendFlag <= wrData[`USBEF_EVT_SUSPEND];
  end

  // read-only cause flag, kept across the internal reset it triggers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      busResetFlag <= 1'b0;
    else if (lineEv.busResetDet)
      busResetFlag <= 1'b1;
  end

  // hardware sets win over a software clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (modRst)
    begin
      txd0Flag <= 1'b0;
      rxd0Flag <= 1'b0;
      txd1Flag <= 1'b0;
      eopFlag <= 1'b0;
      resumeFlag <= 1'b0;
    end
    else
    begin
      if (wrByte && wrIdx == `USBEF_IDX_EVT)
      begin
        txd0Flag <= wrData[`USBEF_EVT_TXD0];
        rxd0Flag <= wrData[`USBEF_EVT_RXD0];
        txd1Flag <= wrData[`USBEF_EVT_TXD1];
        eopFlag <= wrData[`USBEF_EVT_EOP];
        resumeFlag <= wrData[`USBEF_EVT_RESUME];
      end
      if (hostAckValid && hostAckEp == 2'h0)
        txd0Flag <= 1'b1;
      if (rxPacketOk)
        rxd0Flag <= 1'b1;
      if (hostAckValid && hostAckEp != 2'h0)
        txd1Flag <= 1'b1;
      if (lineEv.eopDet)
        eopFlag <= 1'b1;
      if (lineEv.activityDet && suspendFlag)
        resumeFlag <= 1'b1;
    end
  end

  // handshake choice, one cycle after the token
  always_ff @(posedge mclk)
  begin
    if (modRst)
    begin
      hsValid <= 1'b0;
      hsKind <= USBEF_HS_NAK;
      hsToggle <= 1'b0;
      txByteCount <= 4'h0;
    end
    else
    begin
      hsValid <= ep0Tok || intrTok;
      hsToggle <= 1'b0;
      txByteCount <= 4'h0;
      if (ep0Tok)
      begin
        if (ctrl0[`USBEF_CTRL0_STALL])
          hsKind <= USBEF_HS_STALL;
        else if (tokenIsIn)
        begin
          if (!ctrl0[`USBEF_CTRL0_TXEN] || txd0Flag)
            hsKind <= USBEF_HS_NAK;
          else
          begin
            hsKind <= USBEF_HS_DATA;
            hsToggle <= ctrl0[`USBEF_CTRL0_TOGGLE];
            txByteCount <= ctrl0[`USBEF_CTRL0_CNT_HI:`USBEF_CTRL0_CNT_LO];
          end
        end
        else
          hsKind <= (!ctrl0[`USBEF_CTRL0_RXEN] || rxd0Flag) ? USBEF_HS_NAK : USBEF_HS_ACK;
      end
      else if (intrTok)
        hsKind <= (!ctrl1[`USBEF_CTRL1_TXEN] || txd1Flag) ? USBEF_HS_NAK : USBEF_HS_DATA;
    end
  end

  // power and chip reset outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      usbClkRun <= 1'b1;
      usbSuspended <= 1'b0;
      chipReset <= 1'b0;
    end
    else
    begin
      usbClkRun <= !suspendFlag;
      usbSuspended <= suspendFlag;
      chipReset <= lineEv.busResetDet && enaReg[`USBEF_ENA_RSTCHIP];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_suspend_gates_clk: assert property (suspendFlag |=> !usbClkRun && usbSuspended)
    else $error("usb clock not stopped in suspend");
  a_bus_reset_flag: assert property (lineEv.busResetDet |=> busResetFlag)
    else $error("bus reset flag not set");
  a_chip_reset_out: assert property (lineEv.busResetDet && enaReg[`USBEF_ENA_RSTCHIP] |=> chipReset ##1 !chipReset)
    else $error("chip reset pulse wrong");
  a_no_chip_reset: assert property (chipReset |-> $past(enaReg[`USBEF_ENA_RSTCHIP]))
    else $error("chip reset without enable");
  a_tx0_done_set: assert property (hostAckValid && hostAckEp == 2'h0 && !chipReset |=> txd0Flag)
    else $error("ep0 transmit done not set");
  a_ep0_in_nak: assert property (ep0Tok && tokenIsIn && !ctrl0[`USBEF_CTRL0_STALL] && !chipReset
    && (txd0Flag || !ctrl0[`USBEF_CTRL0_TXEN]) |=> hsValid && hsKind == USBEF_HS_NAK)
    else $error("ep0 IN not refused");
  a_rx0_done_set: assert property (rxPacketOk && !chipReset |=> rxd0Flag)
    else $error("ep0 receive done not set");
  a_ep0_out_nak: assert property (ep0Tok && !tokenIsIn && !ctrl0[`USBEF_CTRL0_STALL] && rxd0Flag && !chipReset
    |=> hsValid && hsKind == USBEF_HS_NAK)
    else $error("ep0 OUT not refused");
  a_intr_done_set: assert property (hostAckValid && hostAckEp != 2'h0 && !chipReset |=> txd1Flag)
    else $error("interrupt transmit done not set");
  a_intr_in_nak: assert property (intrTok && txd1Flag && !chipReset |=> hsValid && hsKind == USBEF_HS_NAK)
    else $error("interrupt IN not refused");
  a_eop_flag_sets: assert property (lineEv.eopDet && !chipReset |=> eopFlag)
    else $error("end of packet flag not set");
  a_resume_sticky: assert property (lineEv.activityDet && suspendFlag && !chipReset |=> resumeFlag)
    else $error("resume flag not set");
  a_ctrl0_layout: assert property (wrByte && wrIdx == `USBEF_IDX_CTRL0 && !chipReset |=> ctrl0 == $past(wrData[7:0]))
    else $error("ep0 control write lost");
  a_ep0_data_fields: assert property (ep0Tok && tokenIsIn && !chipReset
    && ctrl0[`USBEF_CTRL0_TXEN] && !txd0Flag && !ctrl0[`USBEF_CTRL0_STALL]
    |=> hsKind == USBEF_HS_DATA && txByteCount == $past(ctrl0[3:0]) && hsToggle == $past(ctrl0[7]))
    else $error("ep0 data answer wrong");
  a_func_off_quiet: assert property (tokenValid && !funcOn |=> !hsValid)
    else $error("token answered while function off");
  a_reset_clears: assert property (chipReset |=> !txd0Flag && !rxd0Flag && !txd1Flag && !eopFlag && !resumeFlag)
    else $error("flags survive chip reset");
  a_reserved_zero: assert property (s_axi_arvalid && s_axi_arready && regIndex(s_axi_araddr) == `USBEF_IDX_EVT
    |=> s_axi_rdata[`USBEF_EVT_RSVD] == 1'b0)
    else $error("reserved bit reads one");
endmodule

// ### dv/usbef_host_model.sv
// Purpose: stand-in for the low-speed host controller: line states, tokens, host ACKs, good OUT packets
// Assumes: J idle is dMinus high, events are one-cycle pulses on mclk
// Notes: token fields turn to inverted values between pulses so stale data never looks valid
`timescale 1ns/1ps
module usbef_host_model (
  // clock
  input wire logic mclk,
  // line
  output logic dPlus,
  output logic dMinus,
  // events
  output logic tokenValid,
  output logic tokenIsIn,
  output logic [1:0] tokenEp,
  output logic hostAckValid,
  output logic [1:0] hostAckEp,
  output logic rxPacketOk
);
  initial
  begin
    dPlus = 1'b0;
    dMinus = 1'b1;
    tokenValid = 1'b0;
    tokenIsIn = 1'b0;
    tokenEp = 2'h0;
    hostAckValid = 1'b0;
    hostAckEp = 2'h0;
    rxPacketOk = 1'b0;
  end

  task automatic sendToken(input logic [1:0] ep, input logic isIn);
    tokenEp <= ep;
    tokenIsIn <= isIn;
    tokenValid <= 1'b1;
    @(posedge mclk);
    tokenValid <= 1'b0;
    tokenEp <= ~ep;
    tokenIsIn <= ~isIn;
  endtask

  // host answers our data packet
  task automatic hostAck(input logic [1:0] ep);
    hostAckEp <= ep;
    hostAckValid <= 1'b1;
    @(posedge mclk);
    hostAckValid <= 1'b0;
    hostAckEp <= ~ep;
  endtask

  task automatic rxOk();
    rxPacketOk <= 1'b1;
    @(posedge mclk);
    rxPacketOk <= 1'b0;
  endtask

  // hold a line state for n cycles, then back to idle J
  task automatic lineHold(input logic dp, input logic dm, input int n);
    dPlus <= dp;
    dMinus <= dm;
    repeat (n) @(posedge mclk);
    dPlus <= 1'b0;
    dMinus <= 1'b1;
  endtask
endmodule

// ### dv/usb_endpoint_status_flags_tb.sv
// Purpose: self-checking bench of the usb event-flag block
// Assumes: short bus reset count, AXI4-Lite master in tasks
// Notes: expectations come from expHs and shadow values passed per call
`timescale 1ns/1ps
`include "usbef_regs.svh"
module usb_endpoint_status_flags_tb;
  import usbef_pkg::*;
  localparam int RCYC = 4;
  localparam logic [11:0] A_ADDR = {`USBEF_IDX_ADDR, 2'b00};
  localparam logic [11:0] A_EVT = {`USBEF_IDX_EVT, 2'b00};
  localparam logic [11:0] A_ENA = {`USBEF_IDX_ENA, 2'b00};
  localparam logic [11:0] A_C0 = {`USBEF_IDX_CTRL0, 2'b00};
  localparam logic [11:0] A_C1 = {`USBEF_IDX_CTRL1, 2'b00};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic dPlus, dMinus, tokenValid, tokenIsIn, hostAckValid, rxPacketOk;
  logic [1:0] tokenEp, hostAckEp;
  logic hsValid, hsToggle, usbClkRun, usbSuspended, chipReset;
  usbef_hs_t hsKind;
  logic [3:0] txByteCount;
  int failCount = 0;
  int compares = 0;
  int rstSeen = 0;
  logic [31:0] lfsr = 32'hb5c4a9a9;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] v;

  always #50 mclk = ~mclk;

  always @(posedge mclk)
    if (chipReset === 1'b1)
      rstSeen <= rstSeen + 1;

  usbef_host_model host (.mclk(mclk), .dPlus(dPlus), .dMinus(dMinus), .tokenValid(tokenValid),
    .tokenIsIn(tokenIsIn), .tokenEp(tokenEp), .hostAckValid(hostAckValid), .hostAckEp(hostAckEp),
    .rxPacketOk(rxPacketOk));

  usbef_core #(.RESET_CYCLES(RCYC)) dut (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .dPlus(dPlus), .dMinus(dMinus), .tokenValid(tokenValid),
    .tokenIsIn(tokenIsIn), .tokenEp(tokenEp), .hostAckValid(hostAckValid), .hostAckEp(hostAckEp),
    .rxPacketOk(rxPacketOk), .hsValid(hsValid), .hsKind(hsKind), .hsToggle(hsToggle),
    .txByteCount(txByteCount), .usbClkRun(usbClkRun), .usbSuspended(usbSuspended), .chipReset(chipReset));

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // stall wins over everything on ep0; ep1 and ep2 share one enable and one done flag
  function automatic usbef_hs_t expHs(input logic [1:0] ep, input logic isIn, input logic [7:0] c0, c1, evt);
    if (ep == 2'h0 && c0[6])
      return USBEF_HS_STALL;
    if (ep != 2'h0)
      return (c1[5] && !evt[2]) ? USBEF_HS_DATA : USBEF_HS_NAK;
    if (isIn)
      return (c0[5] && !evt[4]) ? USBEF_HS_DATA : USBEF_HS_NAK;
    return (c0[4] && !evt[3]) ? USBEF_HS_ACK : USBEF_HS_NAK;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic testDone();
    $display("compares=%0d failCount=%0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // waits as long as it takes; only the watchdog ends a hung transfer
  task automatic axiWrite(input logic [11:0] a, input logic [7:0] val, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, val};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one idle edge so a following call never re-raises bready in the same step
    @(posedge mclk);
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] data, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wrChk(input logic [11:0] a, input logic [7:0] val);
    logic [1:0] resp;
    axiWrite(a, val, resp);
    chk(32'(resp), 32'(`USBEF_RESP_OKAY));
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [7:0] val);
    logic [31:0] data;
    logic [1:0] resp;
    axiRead(a, data, resp);
    chk(data, {24'h0, val});
    chk(32'(resp), 32'(`USBEF_RESP_OKAY));
  endtask

  // answer is looked at in the one cycle that it stands
  task automatic tokCheck(input logic [1:0] ep, input logic isIn, input logic on, input logic [7:0] c0, c1, evt);
    usbef_hs_t k;
    logic ans;
    k = expHs(ep, isIn, c0, c1, evt);
    ans = on && (isIn || ep == 2'h0);
    host.sendToken(ep, isIn);
    #1;
    chk(32'(hsValid), 32'(ans));
    if (ans)
    begin
      chk(32'(hsKind), 32'(k));
      chk(32'({hsToggle, txByteCount}), (ep == 2'h0 && k == USBEF_HS_DATA) ? 32'({c0[7], c0[3:0]}) : 32'h0);
    end
    @(posedge mclk);
  endtask

  initial
  begin
    #2000000;
    failCount++;
    testDone();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdChk(A_C0, 8'h00);
    rdChk(A_EVT, 8'h00);
    chk(32'(usbClkRun), 32'h1);
    tokCheck(2'h0, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    wrChk(A_ADDR, 8'h80);
    axiWrite(12'h000, 8'h5a, r);
    chk(32'(r), 32'(`USBEF_RESP_SLVERR));
    axiRead(12'h000, d, r);
    chk(32'(r), 32'(`USBEF_RESP_SLVERR));
    wrChk(A_EVT, 8'h60);
    rdChk(A_EVT, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsrNext(lfsr);
      v = lfsr[7:0] & 8'hbf;
      wrChk(A_C0, v);
      rdChk(A_C0, v);
      tokCheck(2'h0, lfsr[9], 1'b1, v, 8'h00, 8'h00);
    end
    wrChk(A_C0, 8'h40);
    tokCheck(2'h0, 1'b0, 1'b1, 8'h40, 8'h00, 8'h00);
    rdChk(A_C0, 8'h00);
    wrChk(A_C0, 8'ha5);
    tokCheck(2'h0, 1'b1, 1'b1, 8'ha5, 8'h00, 8'h00);
    host.hostAck(2'h0);
    repeat (2) @(posedge mclk);
    rdChk(A_EVT, 8'h10);
    tokCheck(2'h0, 1'b1, 1'b1, 8'ha5, 8'h00, 8'h10);
    tokCheck(2'h0, 1'b1, 1'b1, 8'ha5, 8'h00, 8'h10);
    wrChk(A_EVT, 8'h00);
    tokCheck(2'h0, 1'b1, 1'b1, 8'ha5, 8'h00, 8'h00);
    wrChk(A_C0, 8'h10);
    tokCheck(2'h0, 1'b0, 1'b1, 8'h10, 8'h00, 8'h00);
    host.rxOk();
    repeat (2) @(posedge mclk);
    rdChk(A_EVT, 8'h08);
    tokCheck(2'h0, 1'b0, 1'b1, 8'h10, 8'h00, 8'h08);
    wrChk(A_EVT, 8'h00);
    tokCheck(2'h2, 1'b1, 1'b1, 8'h10, 8'h00, 8'h00);
    wrChk(A_C1, 8'h20);
    tokCheck(2'h1, 1'b1, 1'b1, 8'h10, 8'h20, 8'h00);
    host.hostAck(2'h2);
    repeat (2) @(posedge mclk);
    rdChk(A_EVT, 8'h04);
    tokCheck(2'h1, 1'b1, 1'b1, 8'h10, 8'h20, 8'h04);
    tokCheck(2'h2, 1'b0, 1'b1, 8'h10, 8'h20, 8'h04);
    wrChk(A_EVT, 8'h00);
    tokCheck(2'h2, 1'b1, 1'b1, 8'h10, 8'h20, 8'h00);
    host.lineHold(1'b0, 1'b0, 2);
    repeat (6) @(posedge mclk);
    rdChk(A_EVT, 8'h02);
    wrChk(A_EVT, 8'h80);
    repeat (2) @(posedge mclk);
    chk(32'({usbClkRun, usbSuspended}), 32'h1);
    host.lineHold(1'b1, 1'b0, 2);
    repeat (6) @(posedge mclk);
    rdChk(A_EVT, 8'h81);
    wrChk(A_EVT, 8'h01);
    repeat (2) @(posedge mclk);
    chk(32'({usbClkRun, usbSuspended}), 32'h2);
    rdChk(A_EVT, 8'h01);
    wrChk(A_EVT, 8'h00);
    // no eop follows the long se0, and bit 1 is still masked on bus reset reads
    host.lineHold(1'b0, 1'b0, RCYC + 4);
    repeat (6) @(posedge mclk);
    wrChk(A_EVT, 8'h00);
    axiRead(A_EVT, d, r);
    chk(d & 32'hfd, 32'h20);
    chk(32'(rstSeen), 32'h0);
    wrChk(A_ENA, 8'h40);
    wrChk(A_C0, 8'ha5);
    host.hostAck(2'h0);
    host.lineHold(1'b0, 1'b0, RCYC + 4);
    repeat (6) @(posedge mclk);
    chk(32'(rstSeen), 32'h1);
    axiRead(A_EVT, d, r);
    chk(d & 32'hfd, 32'h20);
    rdChk(A_C0, 8'h00);
    testDone();
  end
endmodule
